/* hdl/mlhp_host_port.sv */
// Host port of the motion controller: parallel bus, busy and wait pacing,
// interrupt classes with read-to-clear, shared deceleration and start lines.
// Assumes all host pins are asynchronous to CLK and the shared lines have pull-ups.
`include "mlhp_params.svh"
`default_nettype none
// Contract
// R1 - Interrupt output goes low while any unmasked stop, error or event is pending.
// R2 - Main status word shows which interrupt class is pending.
// R3 - Reading main, error or event status clears that pending interrupt.
// R4 - A mask keeps chosen interrupt classes off the interrupt output.
// R5 - Each written command takes four clocks; no access is accepted meanwhile.
// R6 - Wait request is low only while chip select and command busy are low.
// R7 - Accepting a write command drives command busy low.
// R8 - Command busy returns high as soon as processing finishes.
// R9 - Host checks command busy is high before its next access.
// R10 - A host without wait input paces accesses by command busy.
// R11 - In 16-bit width, low data lines carry low byte, high lines high byte.
// R12 - Both mode selects high gives an 8-bit bus; upper data lines ignored.
// R13 - Lowest address bit meaning depends on the mode select setting.
// R14 - Shared deceleration line is open drain; any device pulling low decelerates all.
// R15 - Shared start line is open drain; any device pulling low starts all.
// R16 - Extension status shows current shared deceleration and start levels.
// R17 - Shared lines are only pulled low or released, never driven high.
// R18 - Shared lines are sampled on the reference clock by every device.
module mlhp_host_port
  import mlhp_pkg::*;
#(
  parameter int CAUSE_W = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] D_IN,
  output logic [15:0] D_OUT,
  output logic D_LO_OE_N,
  output logic D_HI_OE_N,
  input wire logic HOST_MODE_SEL0,
  input wire logic HOST_MODE_SEL1,
  output logic INT_N,
  output logic WAIT_REQUEST_N,
  output logic COMMAND_BUSY_N,
  input wire logic SHARED_DECEL_N_IN,
  output logic SHARED_DECEL_N_OUT,
  output logic SHARED_DECEL_N_OE_N,
  input wire logic SHARED_START_N_IN,
  output logic SHARED_START_N_OUT,
  output logic SHARED_START_N_OE_N,
  input wire logic STOP_EVT,
  input wire logic [CAUSE_W-1:0] ERR_EVT,
  input wire logic [CAUSE_W-1:0] EVT_EVT,
  input wire logic [2:0] INT_MASK,
  input wire logic DECEL_REQ,
  input wire logic START_REQ,
  output logic DECEL_SEEN,
  output logic START_SEEN,
  output logic CMD_STB,
  output logic [4:0] CMD_ADDR,
  output logic [15:0] CMD_DATA
);
  localparam int SW = 28;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic cs_s, rd_s, wr_s, decel_s, start_s;
  logic [4:0] addr_s;
  logic [15:0] din_s;
  mlhp_mode_t mode_s;
  logic byte_mode, wr_prev_q, rd_prev_q, busy;
  logic [2:0] cnt_q, cnt_d;
  logic stop_q, stop_d, oe_q, oe_d, stb_q, stb_d, int_n_q, int_n_d;
  logic [CAUSE_W-1:0] err_q, err_d, evt_q, evt_d;
  logic [15:0] dout_q, dout_d, cdata_q, cdata_d, rword;
  logic [4:0] caddr_q, caddr_d;
  logic wr_edge, rd_edge, acc_wr, acc_rd;
  mlhp_irq_t pend;

  // Two flops per pin; only the second stage feeds any logic.
  // R18 - sample shared lines
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= {CS_N, RD_N, WR_N, ADDR, D_IN, HOST_MODE_SEL1, HOST_MODE_SEL0,
                 SHARED_DECEL_N_IN, SHARED_START_N_IN};
      sync_q <= meta_q;
    end
  end
  assign cs_s = ~sync_q[27];
  assign rd_s = ~sync_q[26];
  assign wr_s = ~sync_q[25];
  assign addr_s = sync_q[24:20];
  assign din_s = sync_q[19:4];
  assign mode_s = mlhp_mode_t'(sync_q[3:2]);
  assign decel_s = ~sync_q[1];
  assign start_s = ~sync_q[0];

  // R12 - byte wide bus
  assign byte_mode = (mode_s == MLHP_MODE_BYTE);
  assign busy = (cnt_q != 3'h0);
  assign wr_edge = cs_s & wr_s & ~wr_prev_q;
  assign rd_edge = cs_s & rd_s & ~rd_prev_q;
  // R5 - no access while busy
  assign acc_wr = wr_edge & ~busy;
  assign acc_rd = rd_edge & ~busy;
  assign pend = {|evt_q, |err_q, stop_q};

  // R2 - class bits in main status
  // R16 - shared line levels
  always_comb begin
    rword = `MLHP_RESET_WORD;
    case (addr_s[4:1])
      `MLHP_WADDR_MAIN: begin
        rword[`MLHP_MAIN_STOP] = pend[0];
        rword[`MLHP_MAIN_ERR] = pend[1];
        rword[`MLHP_MAIN_EVT] = pend[2];
        rword[`MLHP_MAIN_BUSY] = busy;
      end
      `MLHP_WADDR_ERR: rword[CAUSE_W-1:0] = err_q;
      `MLHP_WADDR_EVT: rword[CAUSE_W-1:0] = evt_q;
      `MLHP_WADDR_EXT: begin
        rword[`MLHP_EXT_DECEL] = ~decel_s;
        rword[`MLHP_EXT_START] = ~start_s;
      end
      default: rword = `MLHP_RESET_WORD;
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    stop_d = stop_q;
    err_d = err_q;
    evt_d = evt_q;
    oe_d = cs_s & rd_s & (oe_q | acc_rd);
    dout_d = dout_q;
    stb_d = acc_wr;
    caddr_d = caddr_q;
    cdata_d = cdata_q;
    // R7 - busy on accept
    // R8 - release after count
    if (acc_wr) begin
      cnt_d = `MLHP_CMD_CYCLES;
    end else if (busy) begin
      cnt_d = cnt_q - 3'h1;
    end
    // R13 - low address meaning
    // R11 - byte lanes
    if (acc_wr) begin
      caddr_d = byte_mode ? addr_s : {addr_s[4:1], 1'b0};
      cdata_d = byte_mode ? {`MLHP_RESET_BYTE, din_s[7:0]} : din_s;
    end
    if (acc_rd) begin
      if (byte_mode) begin
        dout_d = {`MLHP_RESET_BYTE, addr_s[0] ? rword[15:8] : rword[7:0]};
      end else begin
        dout_d = rword;
      end
    end
    // R3 - read clears, set wins
    if (acc_rd && addr_s[4:1] == `MLHP_WADDR_MAIN) begin
      stop_d = 1'b0;
    end
    if (acc_rd && addr_s[4:1] == `MLHP_WADDR_ERR) begin
      err_d = '0;
    end
    if (acc_rd && addr_s[4:1] == `MLHP_WADDR_EVT) begin
      evt_d = '0;
    end
    stop_d = stop_d | STOP_EVT;
    err_d = err_d | ERR_EVT;
    evt_d = evt_d | EVT_EVT;
    // R1 - request when pending
    // R4 - mask gating
    int_n_d = ~|(pend & ~INT_MASK);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= 3'h0;
      stop_q <= 1'b0;
      err_q <= '0;
      evt_q <= '0;
      oe_q <= 1'b0;
      dout_q <= `MLHP_RESET_WORD;
      stb_q <= 1'b0;
      caddr_q <= 5'h00;
      cdata_q <= `MLHP_RESET_WORD;
      int_n_q <= 1'b1;
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      stop_q <= stop_d;
      err_q <= err_d;
      evt_q <= evt_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      stb_q <= stb_d;
      caddr_q <= caddr_d;
      cdata_q <= cdata_d;
      int_n_q <= int_n_d;
      wr_prev_q <= cs_s & wr_s;
      rd_prev_q <= cs_s & rd_s;
    end
  end

  assign D_OUT = dout_q;
  assign D_LO_OE_N = ~oe_q;
  // R12 - upper lines undriven
  assign D_HI_OE_N = ~(oe_q & ~byte_mode);
  assign INT_N = int_n_q;
  assign COMMAND_BUSY_N = ~busy;
  // R6 - wait only when selected and busy
  assign WAIT_REQUEST_N = ~(cs_s & busy);
  // R17 - pull low or release
  // R14 - shared deceleration drive
  // R15 - shared start drive
  assign SHARED_DECEL_N_OUT = 1'b0;
  assign SHARED_START_N_OUT = 1'b0;
  assign SHARED_DECEL_N_OE_N = ~DECEL_REQ;
  assign SHARED_START_N_OE_N = ~START_REQ;
  assign DECEL_SEEN = decel_s;
  assign START_SEEN = start_s;
  assign CMD_STB = stb_q;
  assign CMD_ADDR = caddr_q;
  assign CMD_DATA = cdata_q;

  property p_busy_len;
    @(posedge CLK) disable iff (!RESETN)
    acc_wr |=> (!COMMAND_BUSY_N) [*4] ##1 COMMAND_BUSY_N;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy not four cycles"); // R5
  property p_busy_set;
    @(posedge CLK) disable iff (!RESETN)
    $fell(COMMAND_BUSY_N) |-> $past(acc_wr) && CMD_STB;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy without accept"); // R7
  property p_wait;
    @(posedge CLK) disable iff (!RESETN)
    !WAIT_REQUEST_N |-> !$past(CS_N, 2) && !COMMAND_BUSY_N;
  endproperty
  a_wait: assert property (p_wait) else $error("wait outside busy select"); // R6
  property p_int;
    @(posedge CLK) disable iff (!RESETN)
    ##1 (INT_N == ~|($past(pend) & ~$past(INT_MASK)));
  endproperty
  a_int: assert property (p_int) else $error("interrupt mismatch"); // R1
  property p_clear;
    @(posedge CLK) disable iff (!RESETN)
    acc_rd && addr_s[4:1] == `MLHP_WADDR_MAIN && !STOP_EVT |=> !stop_q;
  endproperty
  a_clear: assert property (p_clear) else $error("stop not cleared by read"); // R3
  property p_set;
    @(posedge CLK) disable iff (!RESETN)
    |ERR_EVT |=> |err_q ##1 |err_q || $past(acc_rd);
  endproperty
  a_set: assert property (p_set) else $error("error event lost"); // R3
  property p_hi_lane;
    @(posedge CLK) disable iff (!RESETN)
    $past(HOST_MODE_SEL0, 2) && $past(HOST_MODE_SEL1, 2) |-> D_HI_OE_N;
  endproperty
  a_hi_lane: assert property (p_hi_lane) else $error("upper lane driven"); // R12
  property p_shared;
    @(posedge CLK) disable iff (!RESETN)
    DECEL_REQ |-> ##2 DECEL_SEEN;
  endproperty
  a_shared: assert property (p_shared) else $error("shared drive wrong"); // R14
endmodule
`default_nettype wire

/* hdl/mlhp_params.svh */
// Constants of the host port: address decode, status fields, timing.
// Assumes inclusion by the host port module only.
`ifndef MLHP_PARAMS_SVH
`define MLHP_PARAMS_SVH
`define MLHP_CLK_MHZ 50
`define MLHP_CMD_CYCLES 3'h4
`define MLHP_WADDR_MAIN 4'h0
`define MLHP_WADDR_ERR 4'h1
`define MLHP_WADDR_EVT 4'h2
`define MLHP_WADDR_EXT 4'h3
`define MLHP_MAIN_STOP 0
`define MLHP_MAIN_ERR 1
`define MLHP_MAIN_EVT 2
`define MLHP_MAIN_BUSY 3
`define MLHP_EXT_DECEL 0
`define MLHP_EXT_START 1
`define MLHP_RESET_BYTE 8'h00
`define MLHP_RESET_WORD 16'h0000
`endif

/* hdl/mlhp_pkg.sv */
// Types shared by the host port of the motion controller.
// Assumes the constants header is on the include path.
`default_nettype none
package mlhp_pkg;
  typedef enum logic [1:0] {
    MLHP_MODE_STROBE = 2'b00,
    MLHP_MODE_WAITA = 2'b01,
    MLHP_MODE_READY = 2'b10,
    MLHP_MODE_BYTE = 2'b11
  } mlhp_mode_t;
  typedef logic [2:0] mlhp_irq_t;
endpackage
`default_nettype wire

/* dv/mlhp_host_model.sv */
// Host bus model: one access at a time, paced by command busy.
// Assumes it shares the clock with the host port and samples on rising edges.
`default_nettype none
module mlhp_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [4:0] addr,
  output logic [15:0] d_in,
  input wire logic [15:0] d_out,
  input wire logic d_lo_oe_n,
  input wire logic busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 5'h00;
    d_in = 16'h0000;
  end
  task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    // A read keeps driving until its release is synced, so wait for that as well.
    // wait for idle
    while ((busy_n !== 1'b1 || d_lo_oe_n !== 1'b1) && n < 40) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= wr;
    wr_n <= !wr;
    addr <= a;
    d_in <= d;
    do begin
      @(posedge clk);
      n++;
    end while ((wr ? busy_n : d_lo_oe_n) !== 1'b0 && n < 40);
    q = d_out;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // A released bus shows the inverse, so stale data cannot pass.
    d_in <= ~d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* dv/mlhp_host_port_tb_top.sv */
// Bench of the host port: host model accesses, events, shared lines.
// Assumes the shared lines have pull-ups and one other device on each.
`default_nettype none
module mlhp_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, cs_n, rd_n, wr_n, m0 = 1'b0, m1 = 1'b0, stp = 1'b0;
  logic dq = 1'b0, sq = 1'b0, od_n = 1'b1, os_n = 1'b1, int_n, wrq_n, busy_n, loe_n;
  logic dl, sl, doe, dout, soe, sout, dseen, sseen, stb, hoe_n;
  logic [4:0] addr, ca;
  logic [15:0] din, dqo, cd, cmd_d, q;
  logic [7:0] ee = 8'h00, ve = 8'h00;
  logic [2:0] msk = 3'h0;
  logic [4:0] cmd_a;
  int err_total = 0, check_count = 0, cyc = 0, run = 0, blen = 0, wait_lo = 0;
  assign dl = (doe | dout) & od_n;
  assign sl = (soe | sout) & os_n;
  always #10 clk = ~clk;
  mlhp_host_port mlhp_host_port_i (.CLK(clk), .RESETN(rstn), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .ADDR(addr), .D_IN(din), .D_OUT(dqo), .D_LO_OE_N(loe_n), .D_HI_OE_N(hoe_n),
    .HOST_MODE_SEL0(m0), .HOST_MODE_SEL1(m1), .INT_N(int_n), .WAIT_REQUEST_N(wrq_n),
    .COMMAND_BUSY_N(busy_n), .SHARED_DECEL_N_IN(dl), .SHARED_DECEL_N_OUT(dout),
    .SHARED_DECEL_N_OE_N(doe), .SHARED_START_N_IN(sl), .SHARED_START_N_OUT(sout),
    .SHARED_START_N_OE_N(soe), .STOP_EVT(stp), .ERR_EVT(ee), .EVT_EVT(ve), .INT_MASK(msk),
    .DECEL_REQ(dq), .START_REQ(sq), .DECEL_SEEN(dseen), .START_SEEN(sseen),
    .CMD_STB(stb), .CMD_ADDR(ca), .CMD_DATA(cd));
  mlhp_host_model mlhp_host_model_i (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .d_in(din), .d_out(dqo), .d_lo_oe_n(loe_n), .busy_n(busy_n));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic close_out();
    $display("Mismatches %0d of %0d checks", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pulse(input int i);
    stp <= (i == 0);
    ee <= (i == 1) ? 8'h81 : 8'h00;
    ve <= (i == 2) ? 8'h81 : 8'h00;
    @(posedge clk);
    stp <= 1'b0;
    ee <= 8'h00;
    ve <= 8'h00;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stb === 1'b1) begin
      cmd_a <= ca;
      cmd_d <= cd;
    end
    if (busy_n === 1'b0) run <= run + 1;
    else if (run != 0) begin
      blen <= run;
      run <= 0;
    end
    if (busy_n === 1'b0 && wrq_n === 1'b0) wait_lo <= wait_lo + 1;
    if (rstn && busy_n === 1'b1) chk("wait_n", 16'h1, {15'h0, wrq_n});
    if (loe_n === 1'b0) chk("hi_oe_n", {15'h0, m0 & m1}, {15'h0, hoe_n});
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("int_n", 16'h1, {15'h0, int_n});
    chk("busy_n", 16'h1, {15'h0, busy_n});
    mlhp_host_model_i.acc(1'b1, 5'h05, 16'hA55A, q);
    mlhp_host_model_i.acc(1'b1, 5'h09, 16'h1234, q);
    chk("cmd_a", 16'h0008, {11'h0, cmd_a});
    chk("cmd_d", 16'h1234, cmd_d);
    repeat (6) @(posedge clk);
    chk("busy_len", 16'h4, 16'(blen));
    chk("wait_seen", 16'h1, {15'h0, wait_lo > 0});
    m0 <= 1'b1;
    m1 <= 1'b1;
    repeat (4) @(posedge clk);
    mlhp_host_model_i.acc(1'b1, 5'h05, 16'hFF3C, q);
    repeat (2) @(posedge clk);
    chk("cmd_a8", 16'h0005, {11'h0, cmd_a});
    chk("cmd_d8", 16'h003C, cmd_d);
    mlhp_host_model_i.acc(1'b0, 5'h07, 16'h0000, q);
    chk("ext8_hi", 16'h0000, q);
    mlhp_host_model_i.acc(1'b0, 5'h06, 16'h0000, q);
    chk("ext8_lo", 16'h0003, q);
    repeat (4) @(posedge clk);
    m0 <= 1'b0;
    m1 <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      chk("int_low", 16'h0, {15'h0, int_n});
      mlhp_host_model_i.acc(1'b0, 5'h00, 16'h0000, q);
      chk("main", 16'(1 << i), q);
      mlhp_host_model_i.acc(1'b0, 5'(2 * i), 16'h0000, q);
      chk("cause", (i > 0) ? 16'h0081 : 16'h0000, q);
      repeat (3) @(posedge clk);
      chk("int_clr", 16'h1, {15'h0, int_n});
    end
    msk <= 3'h4;
    pulse(2);
    chk("int_mask", 16'h1, {15'h0, int_n});
    msk <= 3'h0;
    repeat (3) @(posedge clk);
    chk("int_unmask", 16'h0, {15'h0, int_n});
    mlhp_host_model_i.acc(1'b0, 5'h04, 16'h0000, q);
    chk("cause_m", 16'h0081, q);
    dq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("decel_drv", 16'h0, {14'h0, doe, dout});
    chk("decel_seen", 16'h1, {15'h0, dseen});
    mlhp_host_model_i.acc(1'b0, 5'h06, 16'h0000, q);
    chk("ext_decel", 16'h0002, q);
    dq <= 1'b0;
    os_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("start_rel", 16'h3, {14'h0, soe, sseen});
    mlhp_host_model_i.acc(1'b0, 5'h06, 16'h0000, q);
    chk("ext_start", 16'h0001, q);
    os_n <= 1'b1;
    sq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("start_drv", 16'h1, {13'h0, soe, sout, sseen});
    sq <= 1'b0;
    close_out();
  end
endmodule
`default_nettype wire
